// [verilog/sbx_pkg.sv]
// Package for the sleep and borrow-subtract execution block.
// Assumes a 16-bit instruction word and an 8-bit data path with 12-bit data addresses.
package sbx_pkg;

    localparam logic [15:0] OP_SLEEP      = 16'h0003;
    localparam logic [15:0] OP_SUBB_VAL   = 16'h5400;
    localparam logic [15:0] OP_SUBB_MSK   = 16'hFC00;
    localparam int          DEST_BIT      = 9;
    localparam int          ACC_BIT       = 8;
    localparam logic [3:0]  ACC_LOW_BANK  = 4'h0;
    localparam logic [3:0]  ACC_HIGH_BANK = 4'hF;
    localparam logic [7:0]  ACC_SPLIT_DEF = 8'h80;
    localparam logic        PWRDN_N_RST   = 1'b1;
    localparam logic        TMOUT_N_RST   = 1'b1;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_READ = 2'b01,
        PH_PROC = 2'b10,
        PH_WRITE = 2'b11
    } sbx_phase_e;

    typedef struct packed {
        logic n;
        logic ov;
        logic c;
        logic dc;
        logic z;
    } sbx_flags_s;

    typedef struct packed {
        sbx_phase_e  phase;
        logic [15:0] instr;
        logic [11:0] addr;
        logic        rd;
        logic        f_wr;
        logic        w_wr;
        logic [7:0]  wdata;
        logic        st_wr;
        sbx_flags_s  flags;
        logic        pwrdn_n;
        logic        tmout_n;
        logic        wdog_clr;
        logic        post_clr;
        logic        asleep;
        logic        busy;
    } sbx_state_s;

    localparam sbx_state_s STATE_RST = '{
        phase: PH_IDLE, instr: 16'h0000, addr: 12'h000, rd: 1'b0, f_wr: 1'b0,
        w_wr: 1'b0, wdata: 8'h00, st_wr: 1'b0, flags: 5'h00, pwrdn_n: PWRDN_N_RST,
        tmout_n: TMOUT_N_RST, wdog_clr: 1'b0, post_clr: 1'b0, asleep: 1'b0, busy: 1'b0};

endpackage

// [verilog/sbx_sub_alu.sv]
// Borrow-subtract arithmetic: w minus f minus the inverted carry, with status flags.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module sbx_sub_alu (
    input  logic [7:0]         w_val,
    input  logic [7:0]         f_val,
    input  logic               carry_in,
    output logic [7:0]         result,
    output sbx_pkg::sbx_flags_s flags
);
    logic [8:0] diff;
    logic [4:0] low_diff;

    always_comb begin
        diff     = {1'b0, w_val} - {1'b0, f_val} - {8'h00, ~carry_in};   // [RQ7]
        low_diff = {1'b0, w_val[3:0]} - {1'b0, f_val[3:0]} - {4'h0, ~carry_in};
        result   = diff[7:0];
        flags.c  = ~diff[8];
        flags.dc = ~low_diff[4];
        flags.n  = diff[7];
        flags.z  = (diff[7:0] == 8'h00);
        flags.ov = (w_val[7] ^ f_val[7]) & (w_val[7] ^ diff[7]);
    end
endmodule

// [verilog/sbx_exec.sv]
// Execution unit for the power-down and subtract-with-borrow instructions.
// Assumes the fetch stage presents one instruction at a time and that file data
// answer in the cycle after the read strobe.
// Contract
// RQ1 - The power-down opcode puts the core to sleep with its oscillator stopped at cycle end.
// RQ2 - Power-down clears the active-low power-down flag.
// RQ3 - Power-down sets the active-low time-out flag, and a watchdog wake-up clears it.
// RQ4 - Power-down clears the watchdog counter and postscaler before the core halts.
// RQ5 - The destination bit sends the subtract result to w when zero and to the file when one.
// RQ6 - The bank bit picks the access bank when zero and the bank select register when one.
// RQ7 - The subtract computes w minus f minus inverted carry and updates all five flags.
`timescale 1ns/100ps
module sbx_exec #(
    parameter logic [7:0] ACCESS_SPLIT = sbx_pkg::ACC_SPLIT_DEF
) (
    input  logic                clk_sys,
    input  logic                nrst,
    input  logic [15:0]         instr,
    input  logic                instr_valid,
    input  logic [7:0]          w_in,
    input  logic [7:0]          file_rdata,
    input  logic [3:0]          bank_select_register,
    input  logic                carry_in,
    input  logic                wake,
    input  logic                wake_by_watchdog,
    output logic [11:0]         file_addr,
    output logic                file_rd,
    output logic                file_wr,
    output logic                w_wr,
    output logic [7:0]          wdata,
    output logic                status_wr,
    output sbx_pkg::sbx_flags_s status_flags,
    output logic                power_down_flag_n,
    output logic                timeout_flag_n,
    output logic                watchdog_counter_clr,
    output logic                postscaler_clr,
    output logic                osc_stop,
    output logic                busy
);
    sbx_pkg::sbx_state_s st_ff;
    sbx_pkg::sbx_state_s nxt_st;
    logic [7:0]          alu_res;
    sbx_pkg::sbx_flags_s alu_flags;

    function automatic logic is_sub(input logic [15:0] op);
        return (op & sbx_pkg::OP_SUBB_MSK) == sbx_pkg::OP_SUBB_VAL;
    endfunction

    function automatic logic is_sleep(input logic [15:0] op);
        return op == sbx_pkg::OP_SLEEP;
    endfunction

    sbx_sub_alu u_alu (
        .w_val    (w_in),
        .f_val    (file_rdata),
        .carry_in (carry_in),
        .result   (alu_res),
        .flags    (alu_flags)
    );

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.rd       = 1'b0;
        nxt_st.f_wr     = 1'b0;
        nxt_st.w_wr     = 1'b0;
        nxt_st.st_wr    = 1'b0;
        nxt_st.wdog_clr = 1'b0;
        nxt_st.post_clr = 1'b0;
        unique case (st_ff.phase)
            sbx_pkg::PH_IDLE: begin
                if (st_ff.asleep) begin
                    if (wake) begin
                        nxt_st.asleep = 1'b0;
                        if (wake_by_watchdog) begin
                            nxt_st.tmout_n = 1'b0;                          // [RQ3]
                        end
                    end
                end else if (instr_valid && (is_sub(instr) || is_sleep(instr))) begin
                    nxt_st.phase = sbx_pkg::PH_READ;
                    nxt_st.instr = instr;
                    nxt_st.busy  = 1'b1;
                    if (is_sub(instr)) begin
                        nxt_st.rd = 1'b1;
                        if (instr[sbx_pkg::ACC_BIT]) begin
                            nxt_st.addr = {bank_select_register, instr[7:0]};  // [RQ6]
                        end else if (instr[7:0] < ACCESS_SPLIT) begin
                            nxt_st.addr = {sbx_pkg::ACC_LOW_BANK, instr[7:0]};   // [RQ6]
                        end else begin
                            nxt_st.addr = {sbx_pkg::ACC_HIGH_BANK, instr[7:0]};  // [RQ6]
                        end
                    end
                end
            end
            sbx_pkg::PH_READ: begin
                nxt_st.phase = sbx_pkg::PH_PROC;
            end
            sbx_pkg::PH_PROC: begin
                nxt_st.phase = sbx_pkg::PH_WRITE;
                if (is_sleep(st_ff.instr)) begin
                    nxt_st.pwrdn_n  = 1'b0;                                 // [RQ2]
                    nxt_st.tmout_n  = 1'b1;                                 // [RQ3]
                    nxt_st.wdog_clr = 1'b1;                                 // [RQ4]
                    nxt_st.post_clr = 1'b1;                                 // [RQ4]
                end else begin
                    nxt_st.wdata = alu_res;                                 // [RQ7]
                    nxt_st.flags = alu_flags;                               // [RQ7]
                    nxt_st.st_wr = 1'b1;
                    nxt_st.f_wr  = st_ff.instr[sbx_pkg::DEST_BIT];          // [RQ5]
                    nxt_st.w_wr  = ~st_ff.instr[sbx_pkg::DEST_BIT];         // [RQ5]
                end
            end
            sbx_pkg::PH_WRITE: begin
                nxt_st.phase = sbx_pkg::PH_IDLE;
                nxt_st.busy  = 1'b0;
                if (is_sleep(st_ff.instr)) begin
                    nxt_st.asleep = 1'b1;                                   // [RQ1]
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff <= sbx_pkg::STATE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign file_addr            = st_ff.addr;
    assign file_rd              = st_ff.rd;
    assign file_wr              = st_ff.f_wr;
    assign w_wr                 = st_ff.w_wr;
    assign wdata                = st_ff.wdata;
    assign status_wr            = st_ff.st_wr;
    assign status_flags         = st_ff.flags;
    assign power_down_flag_n    = st_ff.pwrdn_n;
    assign timeout_flag_n       = st_ff.tmout_n;
    assign watchdog_counter_clr = st_ff.wdog_clr;
    assign postscaler_clr       = st_ff.post_clr;
    assign osc_stop             = st_ff.asleep;
    assign busy                 = st_ff.busy;

    // Expected subtract result formed from the operands seen in the processing phase.
    logic [7:0] chk_res;
    assign chk_res = w_in - file_rdata - {7'h00, ~carry_in};

    a_sleep_halts: assert property ( // [RQ1]
        @(posedge clk_sys) disable iff (!nrst)
        (st_ff.phase == sbx_pkg::PH_WRITE && is_sleep(st_ff.instr)) |=> osc_stop && !busy)
        else $error("sleep did not stop the oscillator at cycle end");

    a_pd_cleared: assert property ( // [RQ2]
        @(posedge clk_sys) disable iff (!nrst)
        $rose(osc_stop) |-> !power_down_flag_n && $past(watchdog_counter_clr))
        else $error("power-down flag not cleared on sleep");

    a_to_set: assert property ( // [RQ3]
        @(posedge clk_sys) disable iff (!nrst)
        watchdog_counter_clr |-> timeout_flag_n ##1 (timeout_flag_n && osc_stop))
        else $error("time-out flag not set on sleep");

    a_to_wake: assert property ( // [RQ3]
        @(posedge clk_sys) disable iff (!nrst)
        (osc_stop && wake && wake_by_watchdog) |=> !timeout_flag_n && !osc_stop)
        else $error("watchdog wake-up did not clear time-out flag");

    a_wdog_before_halt: assert property ( // [RQ4]
        @(posedge clk_sys) disable iff (!nrst)
        (st_ff.phase == sbx_pkg::PH_READ && is_sleep(st_ff.instr))
        |=> ##1 (watchdog_counter_clr && postscaler_clr && !osc_stop) ##1 osc_stop)
        else $error("watchdog not cleared before halt");

    a_dest_select: assert property ( // [RQ5]
        @(posedge clk_sys) disable iff (!nrst)
        status_wr |-> (file_wr == st_ff.instr[sbx_pkg::DEST_BIT]) && (w_wr != file_wr))
        else $error("subtract result sent to wrong destination");

    a_bank_select: assert property ( // [RQ6]
        @(posedge clk_sys) disable iff (!nrst)
        file_rd |-> file_addr[7:0] == st_ff.instr[7:0] && (st_ff.instr[sbx_pkg::ACC_BIT]
            ? file_addr[11:8] == $past(bank_select_register)
            : file_addr[11:8] == ((file_addr[7:0] < ACCESS_SPLIT) ? sbx_pkg::ACC_LOW_BANK
                                                                   : sbx_pkg::ACC_HIGH_BANK)))
        else $error("operand bank selected wrongly");

    a_sub_result: assert property ( // [RQ7]
        @(posedge clk_sys) disable iff (!nrst)
        (st_ff.phase == sbx_pkg::PH_PROC && is_sub(st_ff.instr))
        |=> status_wr && wdata == $past(chk_res) && status_flags.z == (wdata == 8'h00)
            && status_flags.n == wdata[7])
        else $error("subtract result or flags wrong");

    a_sub_timing: assert property ( // [RQ7]
        @(posedge clk_sys) disable iff (!nrst)
        file_rd |-> ##2 status_wr ##1 !busy)
        else $error("subtract did not finish in one instruction cycle");

    a_refuse_asleep: assert property ( // [RQ1]
        @(posedge clk_sys) disable iff (!nrst)
        (osc_stop && !wake) |=> osc_stop && !busy && !file_rd)
        else $error("instruction taken while asleep");

    a_clr_paired: assert property ( // [RQ4]
        @(posedge clk_sys) disable iff (!nrst)
        watchdog_counter_clr == postscaler_clr)
        else $error("watchdog and postscaler clears not paired");

    a_sleep_no_write: assert property ( // [RQ1]
        @(posedge clk_sys) disable iff (!nrst)
        watchdog_counter_clr |-> !status_wr && !file_wr && !w_wr)
        else $error("sleep wrote a result");

    a_strobe_single: assert property ( // [RQ7]
        @(posedge clk_sys) disable iff (!nrst)
        (file_rd || status_wr) |=> !file_rd && !status_wr)
        else $error("strobe held longer than one cycle");

    c_sleep: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(osc_stop));
    c_sub_file: cover property (@(posedge clk_sys) disable iff (!nrst) file_wr);
    c_sub_w_borrow: cover property (
        @(posedge clk_sys) disable iff (!nrst) w_wr && !status_flags.c);
    c_wdog_wake: cover property (
        @(posedge clk_sys) disable iff (!nrst) osc_stop && wake && wake_by_watchdog);
endmodule

// [tb/sbx_mem_model.sv]
// Behavioural data memory standing on the far side of the execution block.
// Assumes reads answer one cycle after the strobe and writes land at the strobe edge.
`timescale 1ns/100ps
module sbx_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [11:0] file_addr,
    input  wire logic        file_rd,
    input  wire logic        file_wr,
    input  wire logic [7:0]  wdata,
    input  wire logic        pre_wr,
    input  wire logic [11:0] pre_addr,
    input  wire logic [7:0]  pre_data,
    output logic      [7:0]  file_rdata
);
    logic [7:0] mem [0:4095];

    // Outside a read answer the bus toggles so a late sample never sees stale data.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            file_rdata <= 8'hA5;
        end else if (file_rd) begin
            file_rdata <= mem[file_addr];
        end else begin
            file_rdata <= ~file_rdata;
        end
    end

    // The bench preloads operands through its own port so the array has one writer.
    always_ff @(posedge clk_sys) begin
        if (pre_wr) begin
            mem[pre_addr] <= pre_data;
        end else if (file_wr) begin
            mem[file_addr] <= wdata;
        end
    end
endmodule

// [tb/sbx_exec_test.sv]
// Self-checking bench for the sleep and borrow-subtract execution block.
// Assumes the memory model answers file reads; all timing follows the four-cycle walk.
`timescale 1ns/100ps
module sbx_exec_test;
    logic                clk_sys = 1'b0;
    logic                nrst = 1'b0;
    logic [15:0]         instr = 16'h0000;
    logic                instr_valid = 1'b0;
    logic [7:0]          w_in = 8'h00;
    logic [7:0]          file_rdata;
    logic [3:0]          bank_select_register = 4'h0;
    logic                carry_in = 1'b0;
    logic                wake = 1'b0;
    logic                wake_by_watchdog = 1'b0;
    logic [11:0]         file_addr;
    logic                file_rd, file_wr, w_wr, status_wr;
    logic [7:0]          wdata;
    sbx_pkg::sbx_flags_s status_flags;
    logic                power_down_flag_n, timeout_flag_n;
    logic                watchdog_counter_clr, postscaler_clr, osc_stop, busy;
    int                  n_errors = 0;
    int                  comparisons = 0;
    logic                pre_wr = 1'b0;
    logic [11:0]         pre_addr = 12'h000;
    logic [7:0]          pre_data = 8'h00;

    always #2 clk_sys = ~clk_sys;

    sbx_exec uut (.clk_sys(clk_sys), .nrst(nrst), .instr(instr), .instr_valid(instr_valid),
        .w_in(w_in), .file_rdata(file_rdata), .bank_select_register(bank_select_register),
        .carry_in(carry_in), .wake(wake), .wake_by_watchdog(wake_by_watchdog),
        .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr), .w_wr(w_wr),
        .wdata(wdata), .status_wr(status_wr), .status_flags(status_flags),
        .power_down_flag_n(power_down_flag_n), .timeout_flag_n(timeout_flag_n),
        .watchdog_counter_clr(watchdog_counter_clr), .postscaler_clr(postscaler_clr),
        .osc_stop(osc_stop), .busy(busy));

    sbx_mem_model mdl (.clk_sys(clk_sys), .nrst(nrst), .file_addr(file_addr),
        .file_rd(file_rd), .file_wr(file_wr), .wdata(wdata),
        .pre_wr(pre_wr), .pre_addr(pre_addr), .pre_data(pre_data), .file_rdata(file_rdata));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One subtract: present the word, then check strobes and result on the fixed walk.
    task automatic sub(input logic d, input logic a, input logic [7:0] f, input logic [3:0] bank,
                       input logic [7:0] w, input logic [7:0] fv, input logic c,
                       input logic [11:0] ea);
        logic [8:0] full;
        logic [4:0] low;
        @(posedge clk_sys);
        pre_wr <= 1'b1;
        pre_addr <= ea;
        pre_data <= fv;
        w_in <= w;
        carry_in <= c;
        bank_select_register <= bank;
        instr <= {6'h15, d, a, f};
        instr_valid <= 1'b1;
        @(posedge clk_sys);
        pre_wr <= 1'b0;
        instr_valid <= 1'b0;
        full = {1'b0, w} - {1'b0, fv} - {8'h00, !c};
        low = {1'b0, w[3:0]} - {1'b0, fv[3:0]} - {4'h0, !c};
        @(negedge clk_sys);
        chk(file_rd, 1'b1);
        chk(file_addr, ea);
        repeat (2) @(negedge clk_sys);
        chk(status_wr, 1'b1);
        chk({file_wr, w_wr}, {d, !d});
        chk(wdata, full[7:0]);
        chk(status_flags, {full[7], (w[7] != fv[7]) && (w[7] != full[7]), !full[8],
                           !low[4], full[7:0] == 8'h00});
        @(negedge clk_sys);
        chk(mdl.mem[ea], d ? full[7:0] : fv);
    endtask

    initial begin
        #40000;
        n_errors++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        chk({power_down_flag_n, timeout_flag_n, osc_stop, busy}, 4'hC);
        sub(1'b1, 1'b0, 8'h10, 4'hA, 8'h02, 8'h03, 1'b1, 12'h010);
        sub(1'b0, 1'b0, 8'h20, 4'h3, 8'h05, 8'h02, 1'b1, 12'h020);
        sub(1'b1, 1'b1, 8'h22, 4'h5, 8'h02, 8'h01, 1'b0, 12'h522);
        sub(1'b0, 1'b0, 8'h90, 4'h5, 8'h80, 8'h01, 1'b1, 12'hF90);
        sub(1'b1, 1'b0, 8'h7F, 4'h7, 8'h00, 8'h00, 1'b1, 12'h07F);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            instr <= 16'h0003;
            instr_valid <= 1'b1;
            @(posedge clk_sys);
            instr_valid <= 1'b0;
            repeat (3) @(negedge clk_sys);
            chk({watchdog_counter_clr, postscaler_clr}, 2'h3);
            chk({power_down_flag_n, timeout_flag_n}, 2'h1);
            chk(osc_stop, 1'b0);
            @(negedge clk_sys);
            chk({osc_stop, busy, watchdog_counter_clr}, 3'h4);
            @(posedge clk_sys);
            instr <= 16'h5610;
            instr_valid <= 1'b1;
            @(posedge clk_sys);
            instr_valid <= 1'b0;
            @(negedge clk_sys);
            chk({file_rd, busy, osc_stop}, 3'h1);
            @(posedge clk_sys);
            wake <= 1'b1;
            wake_by_watchdog <= (i == 0);
            @(posedge clk_sys);
            wake <= 1'b0;
            wake_by_watchdog <= 1'b0;
            @(negedge clk_sys);
            chk({osc_stop, timeout_flag_n}, {1'b0, i != 0});
        end
        sub(1'b0, 1'b1, 8'h01, 4'hF, 8'h7F, 8'hFF, 1'b0, 12'hF01);
        chk(power_down_flag_n, 1'b0);
        @(posedge clk_sys);
        nrst <= 1'b0;
        @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        chk({power_down_flag_n, timeout_flag_n, osc_stop, busy, file_wr}, 5'h18);
        sub(1'b1, 1'b1, 8'hC4, 4'h2, 8'h10, 8'h01, 1'b1, 12'h2C4);
        conclude();
    end
endmodule
